// >>> core/rtccal_pkg.sv
// shared constants for the clock calibration and power-fail block
package rtccal_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // clocks and timing
  localparam int CLK_HZ = 20000000;
  localparam int CLK_PERIOD_NS = 50;
  localparam int OSC_HZ = 32768;
  localparam int PRESCALE_DIV = 128;
  localparam int SEC_TICKS = OSC_HZ / PRESCALE_DIV;
  localparam int FT_HZ = 512;
  localparam int FT_TAP_BIT = $clog2(OSC_HZ / FT_HZ) - 1;
  localparam int REC_TIME_MS = 2;
  localparam int REC_CYCLES = REC_TIME_MS * (CLK_HZ / 1000);
  localparam int ACCESS_TIME_NS = 100;
  localparam int ACCESS_CYCLES = (ACCESS_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int HOST_HOLD_CYCLES = ACCESS_CYCLES + 1;

  ////////////////////////////////////////////////////////////////////////////
  // calibration
  localparam int CAL_CYCLE_MIN = 64;
  localparam int CAL_ELIGIBLE_MIN = 62;
  localparam int CAL_MIN_PER_STEP = 4;
  localparam int CAL_ADJ_OSC = 256;
  localparam int CAL_ADJ_TICKS = CAL_ADJ_OSC / PRESCALE_DIV;
  localparam logic [7:0] CAL_SECOND = 8'h00;

  ////////////////////////////////////////////////////////////////////////////
  // device register map
  localparam logic [12:0] ADDR_CONTROL = 13'h1ff8;
  localparam logic [12:0] ADDR_SECONDS = 13'h1ff9;
  localparam logic [12:0] ADDR_MINUTES = 13'h1ffa;
  localparam logic [12:0] ADDR_HOURS = 13'h1ffb;
  localparam logic [12:0] ADDR_WEEKDAY = 13'h1ffc;
  localparam logic [12:0] ADDR_DATE = 13'h1ffd;
  localparam logic [12:0] ADDR_MONTH = 13'h1ffe;
  localparam logic [12:0] ADDR_YEAR = 13'h1fff;
  localparam int CTL_WRITE_HALT_BIT = 7;
  localparam int CTL_READ_HALT_BIT = 6;
  localparam int CTL_SIGN_BIT = 5;
  localparam int SEC_STOP_BIT = 7;
  localparam int DAY_FT_BIT = 6;
  localparam logic [7:0] CONTROL_RESET = 8'h00;
  localparam logic [7:0] TIME_RESET = 8'h00;
  localparam logic [7:0] DAY_FIRST = 8'h01;
  localparam logic [7:0] SEC_MAX = 8'h59;
  localparam logic [7:0] MIN_MAX = 8'h59;
  localparam logic [7:0] HOUR_MAX = 8'h23;
  localparam logic [7:0] WEEKDAY_MAX = 8'h07;

  ////////////////////////////////////////////////////////////////////////////
  // host command registers
  localparam logic [11:0] HOST_CMD_OFF = 12'h000;
  localparam logic [11:0] HOST_STATUS_OFF = 12'h004;
  localparam int CMD_ADDR_LSB = 0;
  localparam int CMD_WDATA_LSB = 16;
  localparam int CMD_WRITE_BIT = 24;
  localparam int CMD_GO_BIT = 25;
  localparam int CMD_HOLD_BIT = 26;
  localparam int STAT_RDATA_LSB = 0;
  localparam int STAT_BUSY_BIT = 8;
  localparam int STAT_LIVE_BIT = 9;

  function automatic logic [7:0] bcd_inc(input logic [7:0] v);
    if (v[3:0] == 4'h9) begin
      bcd_inc = {v[7:4] + 4'h1, 4'h0};
    end else begin
      bcd_inc = v + 8'h01;
    end
  endfunction : bcd_inc

endpackage : rtccal_pkg

// >>> core/rtccal_if.sv
// sram-style bus between host and clock device
`timescale 1ns/1ps
interface rtccal_if;
  logic [12:0] addr;
  logic ce_n;
  logic oe_n;
  logic we_n;
  logic [7:0] dq_host;
  logic dq_host_oe_n;
  logic [7:0] dq_dev;
  logic dq_dev_oe_n;
  logic [7:0] dq;

  // undriven bus floats high
  assign dq = !dq_dev_oe_n ? dq_dev : (!dq_host_oe_n ? dq_host : 8'hff);

  modport dev (
    input addr, ce_n, oe_n, we_n, dq,
    output dq_dev, dq_dev_oe_n
  );

  modport host (
    output addr, ce_n, oe_n, we_n, dq_host, dq_host_oe_n,
    input dq
  );
endinterface : rtccal_if

// >>> core/rtccal_dev.sv
// clock device: timekeeping, calibration, test tap and power-fail gating
//
// Register access over the sram-style bus was chosen for this implementation.
`timescale 1ns/1ps

////////////////////////////////////////////////////////////////////////////
// Functional notes
// [R1] timebase derived from 32768 Hz oscillator
// [R2] correction applied at divide-by-128 stage
// [R3] five-bit calibration magnitude in control
// [R4] control bit five is correction sign
// [R5] 64-minute cycle, 62 eligible, 256 cycles
// [R6] first four times N minutes corrected
// [R7] test bit shows 512 Hz on bit0
// [R8] test tap taken before correction
// [R9] host holds seconds address during test
// [R10] host sets test bit under write halt
// [R11] host holds extended read, no halt
// [R12] clearing test bit restores seconds readout
// [R13] power fail deselects and protects everything
// [R14] only addressed byte at risk mid-write
// [R15] recovery holdoff after power returns
// [R16] host keeps enables high at power-up
// [R17] stop oscillator for storage
// [R18] write halt bit loads counters on clear
// [R19] read halt freezes visible registers only
// [R20] seconds msb stops oscillator
// [R21] cycle counter advances each minute, wraps
// [R22] test replaces only seconds bit zero
// [R23] zero magnitude never corrects
module rtccal_dev #(
  parameter int REC_CYCLES = rtccal_pkg::REC_CYCLES
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // memory bus
  rtccal_if.dev bus,
  // supply monitor
  input wire logic power_fail_window,
  // backing sram
  output logic [12:0] ram_addr,
  output logic [7:0] ram_wdata,
  output logic ram_we,
  input wire logic [7:0] ram_rdata,
  // status
  output logic osc_running,
  output logic access_blocked
);

  typedef struct packed {
    logic [24:0] acc;
    logic [6:0] pre;
    logic [8:0] sub;
    logic [5:0] cal_min;
    logic [7:0] cnt_sec;
    logic [7:0] cnt_min;
    logic [7:0] cnt_hour;
    logic [7:0] cnt_day;
    logic [7:0] vis_sec;
    logic [7:0] vis_min;
    logic [7:0] vis_hour;
    logic [7:0] vis_day;
    logic [7:0] vis_date;
    logic [7:0] vis_month;
    logic [7:0] vis_year;
    logic [7:0] control;
    logic stop;
    logic ft;
    logic [2:0] pf_sync;
    logic pf;
    logic [31:0] rec_cnt;
    logic rd_q;
    logic [12:0] ram_addr;
    logic [7:0] ram_wdata;
    logic ram_we;
    logic [7:0] dq_dev;
    logic dq_oe_n;
    logic osc_running;
    logic blocked;
  } rtccal_dev_state_t;

  rtccal_dev_state_t st;
  rtccal_dev_state_t next_st;

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    logic [25:0] sum;
    logic osc_tick;
    logic sec_tick;
    logic cal_now;
    logic [6:0] span;
    logic [8:0] sub_end;
    logic blocked;
    logic wr;
    logic [7:0] rdata;
    sum = 26'h0000000;
    osc_tick = 1'b0;
    sec_tick = 1'b0;
    cal_now = 1'b0;
    span = 7'h00;
    sub_end = 9'h000;
    blocked = 1'b0;
    wr = 1'b0;
    rdata = 8'h00;
    next_st = st;

    // supply monitor is asynchronous: filter on agreement of late stages
    next_st.pf_sync = {st.pf_sync[1:0], power_fail_window};
    if (st.pf_sync[1] == st.pf_sync[2]) begin
      next_st.pf = st.pf_sync[2];
    end
    if (st.pf) begin
      next_st.rec_cnt = REC_CYCLES; // R15
    end else if (st.rec_cnt != 32'h00000000) begin
      next_st.rec_cnt = st.rec_cnt - 32'h00000001; // R15
    end
    blocked = st.pf || (st.rec_cnt != 32'h00000000); // R13 R15

    // fractional accumulator stands in for the crystal
    if (!st.stop) begin // R20 R17
      sum = {1'b0, st.acc} + 26'(rtccal_pkg::OSC_HZ);
      if (sum >= 26'(rtccal_pkg::CLK_HZ)) begin // R1
        next_st.acc = 25'(sum - 26'(rtccal_pkg::CLK_HZ));
        osc_tick = 1'b1;
      end else begin
        next_st.acc = sum[24:0];
      end
    end

    // correction window; magnitude 0 gives an empty span
    span = 7'(st.control[4:0] * rtccal_pkg::CAL_MIN_PER_STEP); // R3 R6
    cal_now = (st.control[4:0] != 5'h00) // R23
      && ({1'b0, st.cal_min} < span) // R6
      && (st.cal_min < 6'(rtccal_pkg::CAL_ELIGIBLE_MIN)) // R5
      && (st.cnt_sec == rtccal_pkg::CAL_SECOND); // R21
    if (!cal_now) begin
      sub_end = 9'(rtccal_pkg::SEC_TICKS - 1);
    end else if (st.control[rtccal_pkg::CTL_SIGN_BIT]) begin
      sub_end = 9'(rtccal_pkg::SEC_TICKS - 1 - rtccal_pkg::CAL_ADJ_TICKS); // R4 R5
    end else begin
      sub_end = 9'(rtccal_pkg::SEC_TICKS - 1 + rtccal_pkg::CAL_ADJ_TICKS); // R4 R5
    end

    if (osc_tick) begin
      next_st.pre = st.pre + 7'h01;
      if (st.pre == 7'(rtccal_pkg::PRESCALE_DIV - 1)) begin // R2
        if (st.sub >= sub_end) begin
          next_st.sub = 9'h000;
          sec_tick = 1'b1;
        end else begin
          next_st.sub = st.sub + 9'h001;
        end
      end
    end

    if (sec_tick) begin
      if (st.cnt_sec == rtccal_pkg::SEC_MAX) begin
        next_st.cnt_sec = rtccal_pkg::TIME_RESET;
        next_st.cal_min = st.cal_min + 6'h01; // R21 R5
        if (st.cnt_min == rtccal_pkg::MIN_MAX) begin
          next_st.cnt_min = rtccal_pkg::TIME_RESET;
          if (st.cnt_hour == rtccal_pkg::HOUR_MAX) begin
            next_st.cnt_hour = rtccal_pkg::TIME_RESET;
            if (st.cnt_day == rtccal_pkg::WEEKDAY_MAX) begin
              next_st.cnt_day = rtccal_pkg::DAY_FIRST;
            end else begin
              next_st.cnt_day = st.cnt_day + 8'h01;
            end
          end else begin
            next_st.cnt_hour = rtccal_pkg::bcd_inc(st.cnt_hour);
          end
        end else begin
          next_st.cnt_min = rtccal_pkg::bcd_inc(st.cnt_min);
        end
      end else begin
        next_st.cnt_sec = rtccal_pkg::bcd_inc(st.cnt_sec);
      end
    end

    // either halt freezes the visible copy; counting goes on
    if (!st.control[rtccal_pkg::CTL_WRITE_HALT_BIT]
        && !st.control[rtccal_pkg::CTL_READ_HALT_BIT]) begin // R19 R18
      next_st.vis_sec = st.cnt_sec;
      next_st.vis_min = st.cnt_min;
      next_st.vis_hour = st.cnt_hour;
      next_st.vis_day = st.cnt_day;
    end

    ////////////////////////////////////////////////////////////////////////////
    // writes: everything gated while supply is out of range
    wr = !bus.ce_n && !bus.we_n && !blocked; // R13
    next_st.ram_addr = bus.addr;
    next_st.ram_wdata = bus.dq;
    next_st.ram_we = 1'b0;
    if (wr) begin
      if (bus.addr == rtccal_pkg::ADDR_CONTROL) begin
        next_st.control = bus.dq; // R3 R4
        if (st.control[rtccal_pkg::CTL_WRITE_HALT_BIT]
            && !bus.dq[rtccal_pkg::CTL_WRITE_HALT_BIT]) begin
          next_st.cnt_sec = st.vis_sec; // R18
          next_st.cnt_min = st.vis_min; // R18
          next_st.cnt_hour = st.vis_hour; // R18
          next_st.cnt_day = st.vis_day; // R18
          next_st.sub = 9'h000;
        end
      end else if (bus.addr == rtccal_pkg::ADDR_SECONDS) begin
        next_st.vis_sec = {1'b0, bus.dq[6:0]};
        next_st.stop = bus.dq[rtccal_pkg::SEC_STOP_BIT]; // R20
      end else if (bus.addr == rtccal_pkg::ADDR_MINUTES) begin
        next_st.vis_min = {1'b0, bus.dq[6:0]};
      end else if (bus.addr == rtccal_pkg::ADDR_HOURS) begin
        next_st.vis_hour = {2'b00, bus.dq[5:0]};
      end else if (bus.addr == rtccal_pkg::ADDR_WEEKDAY) begin
        next_st.vis_day = {5'h00, bus.dq[2:0]};
        next_st.ft = bus.dq[rtccal_pkg::DAY_FT_BIT]; // R7 R12
      end else if (bus.addr == rtccal_pkg::ADDR_DATE) begin
        next_st.vis_date = {2'b00, bus.dq[5:0]};
      end else if (bus.addr == rtccal_pkg::ADDR_MONTH) begin
        next_st.vis_month = {3'b000, bus.dq[4:0]};
      end else if (bus.addr == rtccal_pkg::ADDR_YEAR) begin
        next_st.vis_year = bus.dq;
      end else begin
        next_st.ram_we = 1'b1; // R14
      end
    end

    ////////////////////////////////////////////////////////////////////////////
    // reads: address registered one cycle, data the next
    next_st.rd_q = !bus.ce_n && !bus.oe_n && bus.we_n && !blocked; // R13
    rdata = ram_rdata;
    if (st.ram_addr == rtccal_pkg::ADDR_CONTROL) begin
      rdata = st.control;
    end else if (st.ram_addr == rtccal_pkg::ADDR_SECONDS) begin
      // divider tap sits ahead of the correction, so it never shifts
      rdata = {st.stop, st.vis_sec[6:1],
               st.ft ? st.pre[rtccal_pkg::FT_TAP_BIT] : st.vis_sec[0]}; // R7 R8 R22 R12
    end else if (st.ram_addr == rtccal_pkg::ADDR_MINUTES) begin
      rdata = st.vis_min;
    end else if (st.ram_addr == rtccal_pkg::ADDR_HOURS) begin
      rdata = st.vis_hour;
    end else if (st.ram_addr == rtccal_pkg::ADDR_WEEKDAY) begin
      rdata = {1'b0, st.ft, st.vis_day[5:0]};
    end else if (st.ram_addr == rtccal_pkg::ADDR_DATE) begin
      rdata = st.vis_date;
    end else if (st.ram_addr == rtccal_pkg::ADDR_MONTH) begin
      rdata = st.vis_month;
    end else if (st.ram_addr == rtccal_pkg::ADDR_YEAR) begin
      rdata = st.vis_year;
    end
    next_st.dq_dev = rdata;
    next_st.dq_oe_n = !(st.rd_q && !blocked); // R13
    next_st.osc_running = !st.stop;
    next_st.blocked = blocked;
  end

  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st <= '0;
      st.cnt_day <= rtccal_pkg::DAY_FIRST;
      st.vis_day <= rtccal_pkg::DAY_FIRST;
      st.vis_date <= rtccal_pkg::DAY_FIRST;
      st.vis_month <= rtccal_pkg::DAY_FIRST;
      st.control <= rtccal_pkg::CONTROL_RESET;
      st.dq_oe_n <= 1'b1;
    end else begin
      st <= next_st;
    end
  end

  assign bus.dq_dev = st.dq_dev;
  assign bus.dq_dev_oe_n = st.dq_oe_n;
  assign ram_addr = st.ram_addr;
  assign ram_wdata = st.ram_wdata;
  assign ram_we = st.ram_we;
  assign osc_running = st.osc_running;
  assign access_blocked = st.blocked;

endmodule : rtccal_dev

// >>> core/rtccal_host.sv
// host end: apb command registers driving sram-style cycles
`timescale 1ns/1ps
module rtccal_host (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // power-up guard
  input wire logic hold_off,
  // memory bus
  rtccal_if.host bus
);

  typedef struct packed {
    logic [31:0] prdata;
    logic pready;
    logic [12:0] cmd_addr;
    logic [7:0] cmd_wdata;
    logic cmd_write;
    logic cmd_hold;
    logic busy;
    logic [1:0] cnt;
    logic [7:0] rdata;
    logic live_dq0;
    logic [12:0] addr;
    logic ce_n;
    logic oe_n;
    logic we_n;
    logic dq_oe_n;
    logic [7:0] dq_out;
  } rtccal_host_state_t;

  rtccal_host_state_t st;
  rtccal_host_state_t next_st;

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    logic [31:0] r;
    logic go;
    r = 32'h00000000;
    go = 1'b0;
    next_st = st;

    if (st.busy) begin
      if (st.cnt == 2'h0) begin
        if (!st.cmd_write) begin
          next_st.rdata = bus.dq;
        end
        next_st.busy = 1'b0;
        next_st.ce_n = 1'b1;
        next_st.oe_n = 1'b1;
        next_st.we_n = 1'b1;
        next_st.dq_oe_n = 1'b1;
      end else begin
        next_st.cnt = st.cnt - 2'h1;
      end
    end else if (st.cmd_hold && !hold_off) begin
      // extended read without halt keeps the test tap live
      next_st.addr = st.cmd_addr; // R9
      next_st.ce_n = 1'b0; // R9
      next_st.oe_n = 1'b0; // R11
      next_st.we_n = 1'b1;
      next_st.dq_oe_n = 1'b1;
      next_st.rdata = bus.dq;
      next_st.live_dq0 = bus.dq[0];
    end else begin
      next_st.ce_n = 1'b1; // R16
      next_st.oe_n = 1'b1;
      next_st.we_n = 1'b1; // R16
      next_st.dq_oe_n = 1'b1;
    end

    ////////////////////////////////////////////////////////////////////////////
    // apb: read data latched in setup, command write taken in access; pready raised for the access cycle
    next_st.pready = 1'b0;
    if (psel && !penable) begin
      next_st.pready = 1'b1;
      if (paddr == rtccal_pkg::HOST_CMD_OFF) begin
        r[rtccal_pkg::CMD_ADDR_LSB +: 13] = st.cmd_addr;
        r[rtccal_pkg::CMD_WDATA_LSB +: 8] = st.cmd_wdata;
        r[rtccal_pkg::CMD_WRITE_BIT] = st.cmd_write;
        r[rtccal_pkg::CMD_HOLD_BIT] = st.cmd_hold;
      end else if (paddr == rtccal_pkg::HOST_STATUS_OFF) begin
        r[rtccal_pkg::STAT_RDATA_LSB +: 8] = st.rdata;
        r[rtccal_pkg::STAT_BUSY_BIT] = st.busy;
        r[rtccal_pkg::STAT_LIVE_BIT] = st.live_dq0;
      end
      next_st.prdata = r;
    end
    if (psel && penable && st.pready && pwrite && paddr == rtccal_pkg::HOST_CMD_OFF) begin
      next_st.cmd_addr = pwdata[rtccal_pkg::CMD_ADDR_LSB +: 13];
      next_st.cmd_wdata = pwdata[rtccal_pkg::CMD_WDATA_LSB +: 8];
      next_st.cmd_write = pwdata[rtccal_pkg::CMD_WRITE_BIT];
      next_st.cmd_hold = pwdata[rtccal_pkg::CMD_HOLD_BIT];
      go = pwdata[rtccal_pkg::CMD_GO_BIT] && !st.busy && !hold_off; // R16
    end
    if (go) begin
      next_st.busy = 1'b1;
      next_st.cnt = 2'(rtccal_pkg::HOST_HOLD_CYCLES - 1);
      next_st.addr = pwdata[rtccal_pkg::CMD_ADDR_LSB +: 13];
      next_st.dq_out = pwdata[rtccal_pkg::CMD_WDATA_LSB +: 8];
      next_st.ce_n = 1'b0;
      next_st.oe_n = pwdata[rtccal_pkg::CMD_WRITE_BIT];
      next_st.we_n = !pwdata[rtccal_pkg::CMD_WRITE_BIT];
      next_st.dq_oe_n = !pwdata[rtccal_pkg::CMD_WRITE_BIT];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st <= '0;
      st.ce_n <= 1'b1;
      st.oe_n <= 1'b1;
      st.we_n <= 1'b1;
      st.dq_oe_n <= 1'b1;
    end else begin
      st <= next_st;
    end
  end

  assign prdata = st.prdata;
  assign pready = st.pready;
  assign pslverr = 1'b0;
  assign bus.addr = st.addr;
  assign bus.ce_n = st.ce_n;
  assign bus.oe_n = st.oe_n;
  assign bus.we_n = st.we_n;
  assign bus.dq_host = st.dq_out;
  assign bus.dq_host_oe_n = st.dq_oe_n;

endmodule : rtccal_host

// >>> test/rtccal_monitor.sv
// concurrent checks on the sram-style link between host end and device end
`timescale 1ns/1ps
module rtccal_monitor #(
  parameter int REC_CYCLES = 20
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // link
  input wire logic [12:0] addr,
  input wire logic ce_n,
  input wire logic oe_n,
  input wire logic we_n,
  input wire logic [7:0] dq_host,
  input wire logic dq_dev_oe_n,
  // device side
  input wire logic power_fail_window,
  input wire logic access_blocked,
  input wire logic ram_we
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  logic rd;
  int low_cnt;

  assign rd = !ce_n && !oe_n && we_n;

  // saturates, so a long good supply never wraps into a false recovery window
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      low_cnt <= REC_CYCLES + 8;
    end else if (power_fail_window) begin
      low_cnt <= 0;
    end else if (low_cnt < REC_CYCLES + 8) begin
      low_cnt <= low_cnt + 1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  read_drive_a: assert property ((rd && !access_blocked)[*3] |-> !dq_dev_oe_n)
    else $error("device not driving a held read");
  read_release_a: assert property ((!rd)[*3] |-> dq_dev_oe_n)
    else $error("device drives the bus while deselected");
  read_addr_a: assert property (rd && $past(rd) |-> $stable(addr))
    else $error("address moved during a read");
  write_stable_a: assert property (!we_n && !$past(we_n)
    |-> $stable(addr) && $stable(dq_host))
    else $error("address or data moved during a write");
  ram_range_a: assert property (ram_we
    |-> $past(addr) < rtccal_pkg::ADDR_CONTROL && !$past(ce_n) && !$past(we_n))
    else $error("ram write without a matching bus write");
  pf_block_a: assert property (power_fail_window[*6] |-> access_blocked)
    else $error("power fail did not block access");
  blocked_quiet_a: assert property (access_blocked[*2] |-> dq_dev_oe_n)
    else $error("device drives the bus while blocked");
  blocked_nowrite_a: assert property (access_blocked[*3] |-> !ram_we)
    else $error("ram written while blocked");
  rec_hold_a: assert property ($fell(access_blocked) |-> low_cnt >= REC_CYCLES)
    else $error("recovery ended too early");
  rec_end_a: assert property (low_cnt == REC_CYCLES + 8 |-> !access_blocked)
    else $error("recovery never ended");

  cover property (rd[*3] ##1 !dq_dev_oe_n);
  cover property ($fell(access_blocked));
  cover property (ram_we);
endmodule : rtccal_monitor

// >>> test/tb_rtc_calibration_and_power_fail.sv
// self-checking bench: apb into the host end, host end driving the clock device
`timescale 1ns/1ps
`define CHK(nm, exp, got) begin n_compared++; if ((got) !== (exp)) begin bad_count++; \
  $display("[FAIL] %s expected %h seen %h", nm, exp, got); end end
module tb_rtc_calibration_and_power_fail;
  localparam int REC = 20;
  localparam logic [12:0] A_CTL = rtccal_pkg::ADDR_CONTROL;
  localparam logic [12:0] A_SEC = rtccal_pkg::ADDR_SECONDS;
  localparam logic [12:0] A_DAY = rtccal_pkg::ADDR_WEEKDAY;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, hold_off, power_fail_window;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [12:0] ram_addr;
  logic [7:0] ram_wdata, ram_rdata;
  logic ram_we, osc_running, access_blocked;
  logic [7:0] mem [0:8191];
  int bad_count = 0;
  int n_compared = 0;

  rtccal_if rtccal_if_inst ();
  rtccal_host rtccal_host_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .hold_off(hold_off), .bus(rtccal_if_inst.host));
  rtccal_dev #(.REC_CYCLES(REC)) rtccal_dev_inst (.pclk(pclk), .presetn(presetn),
    .bus(rtccal_if_inst.dev), .power_fail_window(power_fail_window), .ram_addr(ram_addr),
    .ram_wdata(ram_wdata), .ram_we(ram_we), .ram_rdata(ram_rdata),
    .osc_running(osc_running), .access_blocked(access_blocked));
  rtccal_monitor #(.REC_CYCLES(REC)) rtccal_monitor_inst (.pclk(pclk), .presetn(presetn),
    .addr(rtccal_if_inst.addr), .ce_n(rtccal_if_inst.ce_n), .oe_n(rtccal_if_inst.oe_n),
    .we_n(rtccal_if_inst.we_n), .dq_host(rtccal_if_inst.dq_host),
    .dq_dev_oe_n(rtccal_if_inst.dq_dev_oe_n), .power_fail_window(power_fail_window),
    .access_blocked(access_blocked), .ram_we(ram_we));

  // backing sram: combinational read, clocked write
  assign ram_rdata = mem[ram_addr];
  always @(posedge pclk) begin
    if (ram_we) begin
      mem[ram_addr] <= ram_wdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    q = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wait_idle(output logic [7:0] q);
    logic [31:0] s;
    // no local limit: a host that never goes idle is caught by the watchdog
    do begin
      apb(1'b0, rtccal_pkg::HOST_STATUS_OFF, 32'h0, s);
    end while (s[rtccal_pkg::STAT_BUSY_BIT] !== 1'b0);
    q = s[7:0];
  endtask : wait_idle

  // a held read keeps ce_n and oe_n low after busy clears, so it is not polled here
  task automatic dev_op(input logic wr, input logic [12:0] a, input logic [7:0] d,
                        input logic hold, output logic [7:0] q);
    logic [31:0] c, s;
    c = 32'h0;
    c[12:0] = a;
    c[23:16] = d;
    c[rtccal_pkg::CMD_WRITE_BIT] = wr;
    c[rtccal_pkg::CMD_GO_BIT] = 1'b1;
    c[rtccal_pkg::CMD_HOLD_BIT] = hold;
    apb(1'b1, rtccal_pkg::HOST_CMD_OFF, c, s);
    q = 8'h00;
    if (!hold) begin
      wait_idle(q);
    end
  endtask : dev_op

  task automatic wr8(input logic [12:0] a, input logic [7:0] d);
    logic [7:0] q;
    dev_op(1'b1, a, d, 1'b0, q);
  endtask : wr8

  task automatic rd8(input logic [12:0] a, output logic [7:0] q);
    dev_op(1'b0, a, 8'h00, 1'b0, q);
  endtask : rd8

  task automatic halt_load(input logic [12:0] a, input logic [7:0] d, input logic [7:0] c);
    wr8(A_CTL, 8'h80);
    wr8(a, d);
    wr8(A_CTL, c);
  endtask : halt_load

  ////////////////////////////////////////////////////////////////////////////
  task automatic t_ram;
    logic [7:0] q;
    logic [31:0] w;
    wr8(13'h0010, 8'h3c);
    wr8(13'h0011, 8'hc3);
    rd8(13'h0010, q);
    `CHK("ram_read", 8'h3c, q)
    `CHK("ram_neighbour", 8'hc3, mem[13'h0011])
    apb(1'b0, 12'h008, 32'h0, w);
    `CHK("unmapped_read", 32'h0, w)
    $display("t_ram done");
  endtask : t_ram

  task automatic t_regs;
    logic [7:0] q;
    halt_load(A_SEC, 8'h25, 8'h3f);
    rd8(A_CTL, q);
    `CHK("cal_positive", 8'h3f, q)
    rd8(A_SEC, q);
    `CHK("sec_loaded", 8'h25, q)
    wr8(A_CTL, 8'h5f);
    wr8(A_SEC, 8'h11);
    rd8(A_SEC, q);
    `CHK("sec_frozen", 8'h11, q)
    wr8(A_CTL, 8'h1f);
    rd8(A_SEC, q);
    `CHK("sec_resumed", 8'h25, q)
    rd8(A_CTL, q);
    `CHK("cal_negative", 8'h1f, q)
    halt_load(A_SEC, 8'ha5, 8'h00);
    repeat (3) @(posedge pclk);
    `CHK("osc_stopped", 1'b0, osc_running)
    halt_load(A_SEC, 8'h25, 8'h00);
    repeat (3) @(posedge pclk);
    `CHK("osc_restarted", 1'b1, osc_running)
    $display("t_regs done");
  endtask : t_regs

  // calibration set to full scale, but with seconds at 25 no correction runs during the measurement
  task automatic t_ft;
    logic [7:0] q;
    logic [31:0] w;
    logic b;
    int n;
    int half;
    half = rtccal_pkg::CLK_HZ / (2 * rtccal_pkg::FT_HZ);
    halt_load(A_DAY, 8'h41, 8'h3f);
    dev_op(1'b0, A_SEC, 8'h00, 1'b1, q);
    repeat (10) @(posedge pclk);
    `CHK("ft_upper_bits", 7'h12, rtccal_if_inst.dq[7:1])
    for (int k = 0; k < 2; k++) begin
      b = rtccal_if_inst.dq[0];
      n = 0;
      while (rtccal_if_inst.dq[0] === b && n < 25000) begin
        @(posedge pclk);
        n++;
      end
    end
    `CHK("ft_half_period", 1'b1, (n >= half - 2 && n <= half + 2))
    apb(1'b0, rtccal_pkg::HOST_STATUS_OFF, 32'h0, w);
    `CHK("ft_status_bits", 7'h12, w[7:1])
    hold_off <= 1'b1;
    repeat (4) @(posedge pclk);
    `CHK("hold_released", 1'b1, rtccal_if_inst.ce_n)
    hold_off <= 1'b0;
    // end the held read first, else the device still drives dq into the next write
    apb(1'b1, rtccal_pkg::HOST_CMD_OFF, 32'h0, w);
    wait_idle(q);
    halt_load(A_DAY, 8'h01, 8'h00);
    rd8(A_SEC, q);
    `CHK("sec_normal", 8'h25, q)
    $display("t_ft done");
  endtask : t_ft

  task automatic t_pf;
    logic [7:0] q;
    logic [31:0] w;
    power_fail_window <= 1'b1;
    repeat (8) @(posedge pclk);
    `CHK("blocked", 1'b1, access_blocked)
    hold_off <= 1'b1;
    apb(1'b1, rtccal_pkg::HOST_CMD_OFF, 32'h03ff_0010, w);
    repeat (6) @(posedge pclk);
    `CHK("no_cycle_in_holdoff", 1'b1, rtccal_if_inst.ce_n)
    hold_off <= 1'b0;
    wr8(13'h0010, 8'hff);
    rd8(13'h0010, q);
    `CHK("read_floats", 8'hff, q)
    power_fail_window <= 1'b0;
    wr8(13'h0011, 8'h00);
    repeat (REC + 10) @(posedge pclk);
    `CHK("unblocked", 1'b0, access_blocked)
    rd8(13'h0010, q);
    `CHK("kept_in_fail", 8'h3c, q)
    rd8(13'h0011, q);
    `CHK("kept_in_recovery", 8'hc3, q)
    $display("t_pf done");
  endtask : t_pf

  task automatic end_of_test;
    $display("compared %0d, mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : end_of_test

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end

  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    hold_off = 1'b0;
    power_fail_window = 1'b0;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    t_ram();
    t_regs();
    t_ft();
    t_pf();
    end_of_test();
  end

  // the test-frequency measurement dominates at about 40k cycles
  initial begin
    repeat (100000) @(posedge pclk);
    bad_count++;
    end_of_test();
  end
endmodule : tb_rtc_calibration_and_power_fail
